// ===== src/psmux_defines.svh
`ifndef PSMUX_DEFINES_SVH
`define PSMUX_DEFINES_SVH

// ==========================================================
// Register map (byte addresses)
`define PSMUX_ADDR_W        4
`define PSMUX_CTRL_OFS      4'h0
`define PSMUX_STAT_OFS      4'h4

// ==========================================================
// Field positions
`define PSMUX_CTRL_FLOAT    0
`define PSMUX_STAT_ADDR_LO  0
`define PSMUX_STAT_ADDR_HI  2
`define PSMUX_STAT_ANEG     3
`define PSMUX_STAT_COMBO    4
`define PSMUX_STAT_LINK     5
`define PSMUX_STAT_TST_EXEC 6
`define PSMUX_STAT_SCRBYP   7
`define PSMUX_STAT_FLOAT    8

// ==========================================================
// Reset values and responses
`define PSMUX_CTRL_RST      1'h0
`define PSMUX_WORD_RST      32'h0000_0000
`define PSMUX_RESP_OKAY     2'h0
`define PSMUX_RESP_SLVERR   2'h2

`endif

// ===== src/psmux_pkg.sv
`default_nettype none

package psmux_pkg;

   typedef enum logic {
      PSMUX_ADAPTER,
      PSMUX_REPEATER
   } psmux_mode_t;

   typedef struct packed {
      logic        aw_have;
      logic [3:0]  awaddr;
      logic        w_have;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        float_req;
      logic [2:0]  mgmt_addr;
      logic        aneg_en;
      logic        combo;
      logic        link_ok;
      logic        test_exec;
      logic        tclk;
      logic        scr_byp;
      logic        float_val;
      logic        float_oe;
   } psmux_state_t;

endpackage

`default_nettype wire

// ===== src/psmux_if.sv
`timescale 1ns/1ps
`default_nettype none

interface psmux_if;
   psmux_pkg::psmux_mode_t mode;
   logic       test_en;
   logic       pin0;
   logic       pin1;
   logic       pin2;
   logic       strap;
   logic       scr_in;
   logic       float_req;
   logic [2:0] mgmt_addr;
   logic       aneg_en;
   logic       combo;
   logic       link_ok;
   logic       test_exec;
   logic       tclk;
   logic       scr_byp;
   logic       float_val;
   logic       float_oe;

   modport dec (
      input  mode, test_en, pin0, pin1, pin2, strap, scr_in, float_req,
      output mgmt_addr, aneg_en, combo, link_ok, test_exec, tclk, scr_byp,
             float_val, float_oe
   );
   modport core (
      output mode, test_en, pin0, pin1, pin2, strap, scr_in, float_req,
      input  mgmt_addr, aneg_en, combo, link_ok, test_exec, tclk, scr_byp,
             float_val, float_oe
   );
endinterface

`default_nettype wire

// ===== src/psmux_pin_decode.sv
`timescale 1ns/1ps
`default_nettype none

module psmux_pin_decode (
   psmux_if.dec p
);
   logic rep;
   logic combo;

   always_comb begin
      rep   = (p.mode == psmux_pkg::PSMUX_REPEATER);
      combo = !rep && p.strap;
      // Test use of the low address pins overrides the address
      p.mgmt_addr[0] = rep && !p.test_en && p.pin0;
      p.mgmt_addr[1] = rep && !p.test_en && p.pin1;
      p.mgmt_addr[2] = rep && p.pin2;
      p.test_exec    = p.test_en && p.pin1;
      p.tclk         = p.test_en && p.pin0;
      p.aneg_en      = rep ? !p.strap : 1'b1;
      p.combo        = combo;
      p.link_ok      = combo && !p.pin2;
      p.float_oe     = combo;
      p.float_val    = combo && p.float_req;
      p.scr_byp      = p.scr_in;
   end

endmodule // psmux_pin_decode

`default_nettype wire

// ===== src/psmux_top.sv
// Overview of operation
// - In repeater mode with test enable low the address-bit-one pin gives management address bit 1.
// - In repeater mode with test enable low the address-bit-zero pin gives management address bit 0.
// - With test enable high the address-bit-one pin is the test execute command.
// - With test enable high the address-bit-zero pin is the test clock, not an address bit.
// - In repeater mode a high auto-negotiation strap disables auto-negotiation.
// - In adapter mode the shared strap enables combo mode and the slave PHY pins.
// - In adapter combo mode a low link status pin means the slave link is valid.
// - A high scrambler bypass input bypasses scrambler and descrambler.
// - In repeater mode the address-bit-two pin gives management address bit 2.
// - In adapter mode float plus combo makes the slave PHY float its outputs.
`timescale 1ns/1ps
`default_nettype none
`include "psmux_defines.svh"

module psmux_top (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   // Mode and strap pins
   input  wire logic        i_repeater_mode,
   input  wire logic        i_test_enable,
   input  wire logic        i_mgmt_addr_bit0_pin,
   input  wire logic        i_mgmt_addr_bit1_pin,
   input  wire logic        i_mgmt_addr_bit2_pin,
   input  wire logic        i_autoneg_off_strap,
   input  wire logic        i_scrambler_bypass,
   // Decoded pin functions
   output logic [2:0]       o_mgmt_addr,
   output logic             o_autoneg_enable,
   output logic             o_combo_mode_enable,
   output logic             o_slave_link_valid,
   output logic             o_test_execute_cmd,
   output logic             o_test_clk,
   output logic             o_scrambler_bypass,
   output logic             o_slave_output_float_o,
   output logic             o_slave_output_float_oe,
   // AXI4-Lite write
   input  wire logic [3:0]  i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   output logic [1:0]       o_s_axi_bresp,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]  i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   output logic [31:0]      o_s_axi_rdata,
   output logic [1:0]       o_s_axi_rresp,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready
);

   psmux_pkg::psmux_state_t st_reg;
   psmux_pkg::psmux_state_t st_next;
   psmux_if                 pins ();

   // ==========================================================
   // Pin function decode
   assign pins.mode      = i_repeater_mode ? psmux_pkg::PSMUX_REPEATER
                                           : psmux_pkg::PSMUX_ADAPTER;
   assign pins.test_en   = i_test_enable;
   assign pins.pin0      = i_mgmt_addr_bit0_pin;
   assign pins.pin1      = i_mgmt_addr_bit1_pin;
   assign pins.pin2      = i_mgmt_addr_bit2_pin;
   assign pins.strap     = i_autoneg_off_strap;
   assign pins.scr_in    = i_scrambler_bypass;
   assign pins.float_req = st_reg.float_req;

   psmux_pin_decode u_decode (
      .p (pins.dec)
   );

   // ==========================================================
   // Bus handshakes
   // One write and one read in flight; channels stall until answered
   assign o_s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
   assign o_s_axi_wready  = !st_reg.w_have && !st_reg.bvalid;
   assign o_s_axi_arready = !st_reg.rvalid;

   // ==========================================================
   // Next state
   always_comb begin
      logic        aw_hs;
      logic        w_hs;
      logic [31:0] stat;
      aw_hs   = i_s_axi_awvalid && o_s_axi_awready;
      w_hs    = i_s_axi_wvalid && o_s_axi_wready;
      stat    = `PSMUX_WORD_RST;
      st_next = st_reg;

      // Pin functions registered so data outputs come from flops
      st_next.mgmt_addr = pins.mgmt_addr;
      st_next.aneg_en   = pins.aneg_en;
      st_next.combo     = pins.combo;
      st_next.link_ok   = pins.link_ok;
      st_next.test_exec = pins.test_exec;
      st_next.tclk      = pins.tclk;
      st_next.scr_byp   = pins.scr_byp;
      st_next.float_val = pins.float_val;
      st_next.float_oe  = pins.float_oe;

      stat[`PSMUX_STAT_ADDR_HI:`PSMUX_STAT_ADDR_LO] = st_reg.mgmt_addr;
      stat[`PSMUX_STAT_ANEG]   = st_reg.aneg_en;
      stat[`PSMUX_STAT_COMBO]  = st_reg.combo;
      stat[`PSMUX_STAT_LINK]   = st_reg.link_ok;
      stat[`PSMUX_STAT_TST_EXEC] = st_reg.test_exec;
      stat[`PSMUX_STAT_SCRBYP] = st_reg.scr_byp;
      stat[`PSMUX_STAT_FLOAT]  = st_reg.float_val;

      // Write path: address and data in either order
      if (aw_hs) begin
         st_next.aw_have = 1'b1;
         st_next.awaddr  = i_s_axi_awaddr;
      end
      if (w_hs) begin
         st_next.w_have = 1'b1;
         st_next.wdata  = i_s_axi_wdata;
         st_next.wstrb  = i_s_axi_wstrb;
      end
      if (st_next.aw_have && st_next.w_have && !st_reg.bvalid) begin
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         if (st_next.awaddr == `PSMUX_CTRL_OFS) begin
            st_next.bresp = `PSMUX_RESP_OKAY;
            if (st_next.wstrb[0]) begin
               st_next.float_req = st_next.wdata[`PSMUX_CTRL_FLOAT];
            end
         end else if (st_next.awaddr == `PSMUX_STAT_OFS) begin
            st_next.bresp = `PSMUX_RESP_OKAY;
         end else begin
            st_next.bresp = `PSMUX_RESP_SLVERR;
         end
      end else if (st_reg.bvalid && i_s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // Read path
      if (i_s_axi_arvalid && o_s_axi_arready) begin
         st_next.rvalid = 1'b1;
         if (i_s_axi_araddr == `PSMUX_CTRL_OFS) begin
            st_next.rdata = `PSMUX_WORD_RST;
            st_next.rdata[`PSMUX_CTRL_FLOAT] = st_reg.float_req;
            st_next.rresp = `PSMUX_RESP_OKAY;
         end else if (i_s_axi_araddr == `PSMUX_STAT_OFS) begin
            st_next.rdata = stat;
            st_next.rresp = `PSMUX_RESP_OKAY;
         end else begin
            st_next.rdata = `PSMUX_WORD_RST;
            st_next.rresp = `PSMUX_RESP_SLVERR;
         end
      end else if (st_reg.rvalid && i_s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg         <= '0;
         st_reg.aneg_en <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign o_mgmt_addr             = st_reg.mgmt_addr;
   assign o_autoneg_enable        = st_reg.aneg_en;
   assign o_combo_mode_enable     = st_reg.combo;
   assign o_slave_link_valid      = st_reg.link_ok;
   assign o_test_execute_cmd      = st_reg.test_exec;
   assign o_test_clk              = st_reg.tclk;
   assign o_scrambler_bypass      = st_reg.scr_byp;
   assign o_slave_output_float_o  = st_reg.float_val;
   assign o_slave_output_float_oe = st_reg.float_oe;
   assign o_s_axi_bvalid          = st_reg.bvalid;
   assign o_s_axi_bresp           = st_reg.bresp;
   assign o_s_axi_rvalid          = st_reg.rvalid;
   assign o_s_axi_rdata           = st_reg.rdata;
   assign o_s_axi_rresp           = st_reg.rresp;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   a_addr_bit1_follow: assert property (
      i_repeater_mode && !i_test_enable |=> o_mgmt_addr[1] == $past(i_mgmt_addr_bit1_pin))
      else $error("address bit 1 does not follow its pin");
   a_addr_bit0_follow: assert property (
      i_repeater_mode && !i_test_enable |=> o_mgmt_addr[0] == $past(i_mgmt_addr_bit0_pin))
      else $error("address bit 0 does not follow its pin");
   a_test_exec_pin: assert property (
      i_test_enable |=> o_test_execute_cmd == $past(i_mgmt_addr_bit1_pin) && !o_mgmt_addr[1])
      else $error("test execute not taken from bit 1 pin");
   a_test_clk_pin: assert property (
      i_test_enable |=> o_test_clk == $past(i_mgmt_addr_bit0_pin) && !o_mgmt_addr[0])
      else $error("test clock not taken from bit 0 pin");
   a_aneg_disable: assert property (
      i_repeater_mode |=> o_autoneg_enable != $past(i_autoneg_off_strap))
      else $error("auto-negotiation enable wrong in repeater mode");
   a_combo_enable: assert property (
      !i_repeater_mode && i_autoneg_off_strap |=> o_combo_mode_enable && o_slave_output_float_oe)
      else $error("combo mode not enabled");
   a_link_valid_low: assert property (
      !i_repeater_mode && i_autoneg_off_strap && !i_mgmt_addr_bit2_pin |=> o_slave_link_valid)
      else $error("low link status not seen as valid");
   a_scr_bypass: assert property (
      o_scrambler_bypass == $past(i_scrambler_bypass))
      else $error("scrambler bypass does not follow input");
   a_addr_bit2_follow: assert property (
      i_repeater_mode |=> o_mgmt_addr[2] == $past(i_mgmt_addr_bit2_pin))
      else $error("address bit 2 does not follow its pin");
   a_float_needs_combo: assert property (
      o_slave_output_float_o |-> o_combo_mode_enable && $past(st_reg.float_req))
      else $error("slave float without combo mode or request");
   a_write_answer: assert property (
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |=> o_s_axi_bvalid)
      else $error("write not answered next cycle");

   c_combo_link: cover property (o_combo_mode_enable && o_slave_link_valid);
   c_float_on: cover property (o_slave_output_float_o && o_slave_output_float_oe);
   c_test_mode: cover property (o_test_execute_cmd ##1 o_test_clk);
   c_bad_read: cover property (o_s_axi_rvalid && o_s_axi_rresp == `PSMUX_RESP_SLVERR);

endmodule // psmux_top

`default_nettype wire

// ===== testbench/psmux_slave_phy.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Slave T4 PHY as seen on the shared pins
module psmux_slave_phy (
   // Device side
   input  wire logic i_combo_oe,
   input  wire logic i_float_o,
   // Bench command
   input  wire logic i_link_up,
   // Link status pin, pulled up on the board
   output logic      o_link_ok_n
);
   // A floated slave leaves the board pull-up in charge of the pin
   assign o_link_ok_n = (i_combo_oe && i_float_o) ? 1'b1 : !i_link_up;
endmodule // psmux_slave_phy

`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   // ==========================================
   // Signals
   logic        clk, nrst, rep, te, b0, b1, b2, strap, scr, link_up, link_n, pin2, ctrl;
   logic [2:0]  addr;
   logic        aneg, combo, lvalid, tst_exec, tclk, scro, flo, floe;
   logic [3:0]  awaddr, wstrb, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [7:0]  v;
   int          failures, num_checks, seed, i;
   logic [7:0]  corners [4] = '{8'hb8, 8'hf8, 8'h05, 8'h65};

   always #20 clk = ~clk;
   // Address bit two pin is shared with the slave link status
   assign pin2 = rep ? b2 : link_n;

   psmux_slave_phy phy (.i_combo_oe(floe), .i_float_o(flo), .i_link_up(link_up),
                        .o_link_ok_n(link_n));

   psmux_top dut (
      .i_core_clk(clk), .i_nrst(nrst), .i_repeater_mode(rep), .i_test_enable(te),
      .i_mgmt_addr_bit0_pin(b0), .i_mgmt_addr_bit1_pin(b1), .i_mgmt_addr_bit2_pin(pin2),
      .i_autoneg_off_strap(strap), .i_scrambler_bypass(scr), .o_mgmt_addr(addr),
      .o_autoneg_enable(aneg), .o_combo_mode_enable(combo), .o_slave_link_valid(lvalid),
      .o_test_execute_cmd(tst_exec), .o_test_clk(tclk), .o_scrambler_bypass(scro),
      .o_slave_output_float_o(flo), .o_slave_output_float_oe(floe),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

   // ==========================================
   // Expectations
   function automatic logic [10:0] exp_pins();
      logic cmb;
      logic p2;
      cmb = !rep && strap;
      p2 = rep ? b2 : ((cmb && ctrl) ? 1'b1 : !link_up);
      exp_pins = {cmb, cmb && ctrl, scr, te && b1, te && b0, cmb && !p2, cmb,
                  rep ? !strap : 1'b1, rep ? {b2, b1 && !te, b0 && !te} : 3'h0};
   endfunction

   function automatic logic [31:0] exp_stat(input logic [10:0] e);
      exp_stat = {23'h0, e[9:7], e[5:0]};
   endfunction

   // ==========================================
   // Compare tasks
   task automatic check_pins(input logic [10:0] e);
      logic [10:0] g;
      g = {floe, flo, scro, tst_exec, tclk, lvalid, combo, aneg, addr};
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t pins %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_word(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t word %h expected %h", $time, g, e);
      end
   endtask

   // ==========================================
   // Bus master; handshakes and answers are taken at the rising edge itself
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && n < 40) begin
         @(posedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         if (tb) check_word({30'h0, bresp}, {30'h0, er});
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         n++;
      end
      if (!tb) begin
         failures++;
         $display("[ERR] %0t write not answered", $time);
      end
      // Let an edge pass so the next request never reassigns in this step
      @(posedge clk);
   endtask

   task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic ta, tr;
      n = 0;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr && n < 40) begin
         @(posedge clk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         if (tr) begin
            check_word(rdata, ed);
            check_word({30'h0, rresp}, {30'h0, er});
         end
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
         n++;
      end
      if (!tr) begin
         failures++;
         $display("[ERR] %0t read not answered", $time);
      end
      @(posedge clk);
   endtask

   // Hold a pin set long enough for the slave answer to settle
   task automatic step(input logic [7:0] p);
      {rep, te, b0, b1, b2, strap, scr, link_up} <= p;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check_pins(exp_pins());
      @(posedge clk);
      axi_read(4'h4, exp_stat(exp_pins()), 2'h0);
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================
   // Watchdog, about 27 times the expected run
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {rep, te, b0, b1, b2, strap, scr, link_up, ctrl} = 9'h0;
      {awaddr, wstrb, araddr, wdata} = 44'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      failures = 0;
      num_checks = 0;
      seed = 67112;
      repeat (12) @(posedge clk);
      @(negedge clk);
      check_pins(11'h008);
      @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      // Register map, read-only status and unmapped places
      axi_read(4'h0, 32'h0, 2'h0);
      axi_write(4'h4, 32'hffff_ffff, 2'h0);
      axi_write(4'h8, 32'h1, 2'h2);
      axi_read(4'hc, 32'h0, 2'h2);
      ctrl = 1'b1;
      axi_write(4'h0, 32'h1, 2'h0);
      axi_read(4'h0, 32'h1, 2'h0);
      $display("test registers done");
      // Floated slave drops the link, restoring the drive brings it back
      step(8'h05);
      ctrl = 1'b0;
      axi_write(4'h0, 32'h0, 2'h0);
      for (i = 0; i < 4; i++) step(corners[i]);
      $display("test corners done");
      for (i = 0; i < 80; i++) begin
         v = 8'($random(seed));
         if (i % 8 == 0) begin
            ctrl = v[3];
            axi_write(4'h0, {31'h0, ctrl}, 2'h0);
         end
         step(v);
      end
      $display("test random done");
      print_verdict();
   end
endmodule // tb_top

`default_nettype wire
